// file: rtl/prcrfs_map.vh
`ifndef PRCRFS_MAP_VH
`define PRCRFS_MAP_VH
// avalon word indexes (byte address is four times the index)
`define PRCRFS_REG_CTRL 3'h0
`define PRCRFS_REG_BASE 3'h1
`define PRCRFS_REG_STATUS 3'h2
`define PRCRFS_REG_CFG 3'h3
`define PRCRFS_REG_ICNT 3'h4
`define PRCRFS_REG_FETCH 3'h5
// core control register fields
`define PRCRFS_CTRL_SLEEP 0
`define PRCRFS_CTRL_CLKIRQ_EN 1
`define PRCRFS_CTRL_DEVIRQ_EN 2
`define PRCRFS_CTRL_EN_RESET 2'h0
`define PRCRFS_BASE_RESET 32'h00000000
// status register fields
`define PRCRFS_STAT_WAKE 16
`define PRCRFS_STAT_SLEEP 17
`define PRCRFS_STAT_ROM_LSB 18
// pll divisor pairs
`define PRCRFS_XDIV_SLOW 5'h10
`define PRCRFS_ZDIV_SLOW 6'h20
`define PRCRFS_XDIV_HALF 5'h02
`define PRCRFS_ZDIV_HALF 6'h04
`define PRCRFS_XDIV_FULL 5'h01
`define PRCRFS_ZDIV_FULL 6'h02
// duration counts in mclk cycles
`define PRCRFS_CNT_W 14
`define PRCRFS_RAMP1_CYCLES 14'h100C
`define PRCRFS_RAMP2_CYCLES 14'h200D
`define PRCRFS_LOW_CYCLES 14'h0108
`define PRCRFS_BUILT_IN_SELF_TEST_CYCLES 14'h0040
`define PRCRFS_SELFINIT_CYCLES 14'h0080
// serial boot rom stream
`define PRCRFS_ROM_HALF_LAST 3'h3
`define PRCRFS_ROM_FIELD_LAST 16'h000F
// fault restart offset from the privileged code base
`define PRCRFS_FAULT_OFFSET 32'h00000780
`endif

// file: rtl/prcrfs_sync.v
`default_nettype none
// two flip-flop synchroniser for a bundle of pin levels
module prcrfs_sync #(
    parameter W = 1
) (
    input wire mclk,
    input wire rst_n,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    // first stage, read only by the second stage
    reg [W-1:0] meta;

    always @(posedge mclk) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// file: rtl/prcrfs_dur_counter.v
`default_nettype none
`include "prcrfs_map.vh"
// duration counter: load restarts at one, so a state lasts exactly target cycles
module prcrfs_dur_counter (
    input wire mclk,
    input wire rst_n,
    input wire load,
    input wire [`PRCRFS_CNT_W-1:0] target,
    output wire done
);
    localparam [`PRCRFS_CNT_W-1:0] CNT_ONE = {{(`PRCRFS_CNT_W-1){1'b0}}, 1'b1};
    reg [`PRCRFS_CNT_W-1:0] count; // cycles since load
    reg [`PRCRFS_CNT_W-1:0] limit; // value loaded for this state

    // done is combinational so a state can react on the very cycle
    assign done = (count == limit);

    // advance once per cycle, park at the limit
    always @(posedge mclk) begin
        if (!rst_n) begin
            count <= {`PRCRFS_CNT_W{1'b0}};
            limit <= {`PRCRFS_CNT_W{1'b0}};
        end else if (load) begin
            // the first cycle in the new state already counts
            count <= CNT_ONE;
            limit <= target;
        end else if (count != limit) begin
            count <= count + CNT_ONE;
        end
    end
endmodule
`default_nettype wire

// file: rtl/prcrfs_top.v
`default_nettype none
`include "prcrfs_map.vh"
module prcrfs_top #(
    parameter [`PRCRFS_CNT_W-1:0] HALF_RAMP_CYCLES = `PRCRFS_RAMP1_CYCLES,
    parameter [`PRCRFS_CNT_W-1:0] FULL_RAMP_CYCLES = `PRCRFS_RAMP2_CYCLES
) (
    input wire mclk,
    input wire rst_n,
    input wire [2:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire chip_reset_n,
    input wire pll_supply_ok,
    input wire core_supply_ok,
    input wire power_good,
    input wire forwarded_clock_reset,
    input wire frame_reference_clock,
    input wire clock_irq,
    input wire device_irq,
    input wire boot_rom_data,
    output reg boot_rom_output_enable_n,
    output reg boot_rom_clock,
    output reg [4:0] pll_x_div,
    output reg [5:0] pll_z_div,
    output reg internal_reset_n,
    output reg fwd_if_reset,
    output reg fault_reset,
    output reg run_active,
    output reg icache_enable,
    output reg fetch_from_memory,
    output reg [31:0] fetch_addr
);
    ////////////////////////////////////////////////////////////////////
    // states, one-hot
    localparam [15:0] S_COLD = 16'h0001;
    localparam [15:0] S_SETTLE = 16'h0002;
    localparam [15:0] S_NOMINAL = 16'h0004;
    localparam [15:0] S_RAMP1 = 16'h0008;
    localparam [15:0] S_RAMP2 = 16'h0010;
    localparam [15:0] S_FWD0 = 16'h0020;
    localparam [15:0] S_BUILT_IN_SELF_TEST = 16'h0040;
    localparam [15:0] S_SELFINIT = 16'h0080;
    localparam [15:0] S_FWD1 = 16'h0100;
    localparam [15:0] S_RUN = 16'h0200;
    localparam [15:0] S_FAULT = 16'h0400;
    localparam [15:0] S_DOWN1 = 16'h0800;
    localparam [15:0] S_DOWN2 = 16'h1000;
    localparam [15:0] S_DOWN3 = 16'h2000;
    localparam [15:0] S_WAIT_IRQ = 16'h4000;
    localparam [15:0] S_WAIT_RESET = 16'h8000;
    // rom stream phases, one-hot
    localparam [3:0] ROM_CFG = 4'h1;
    localparam [3:0] ROM_CNT = 4'h2;
    localparam [3:0] ROM_DATA = 4'h4;
    localparam [3:0] ROM_DONE = 4'h8;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    wire [8:0] pin_s; // all pins after two flops
    prcrfs_sync #(
        .W(9)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d({boot_rom_data, device_irq, clock_irq, frame_reference_clock,
            forwarded_clock_reset, power_good, core_supply_ok,
            pll_supply_ok, chip_reset_n}),
        .q(pin_s)
    );
    wire chip_n_s = pin_s[0]; // chip reset, low is asserted
    wire pll_ok_s = pin_s[1];
    wire core_ok_s = pin_s[2];
    wire pgood_s = pin_s[3];
    wire fcr_s = pin_s[4]; // forwarded clock reset
    wire frame_s = pin_s[5];
    wire clk_irq_s = pin_s[6];
    wire dev_irq_s = pin_s[7];
    wire rom_s = pin_s[8];

    ////////////////////////////////////////////////////////////////////
    // aligned frame copy and forward reset sampling
    reg frame_q; // internal copy, one cycle behind frame_s
    reg fcr_smp; // forward reset as seen at the last frame edge
    wire frame_fall = frame_q & ~frame_s;
    wire frame_rise = ~frame_q & frame_s;
    // frame and reset share sync latency, so edge alignment survives
    wire release_fall = frame_fall & fcr_smp & ~fcr_s;
    wire release_rise = frame_rise & fcr_smp & ~fcr_s;

    // the copy advances every cycle; reset is captured only on its edges
    always @(posedge mclk) begin
        if (!rst_n) begin
            frame_q <= 1'b0;
            fcr_smp <= 1'b0;
        end else begin
            frame_q <= frame_s;
            if (frame_fall | frame_rise) begin
                fcr_smp <= fcr_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state and mode flags
    reg [15:0] state;
    reg [15:0] next_state;
    reg wake; // current bring-up comes from sleep
    reg sleep_mode; // current down ramp was asked by software
    reg sleep_req; // pending software sleep request
    reg [1:0] irq_en; // clock and device interrupt enables
    reg [31:0] code_base; // privileged code base
    reg cnt_load;
    reg [`PRCRFS_CNT_W-1:0] cnt_target;
    wire cnt_done;
    reg [3:0] rom_phase;
    wire irq_hit = (clk_irq_s & irq_en[0]) | (dev_irq_s & irq_en[1]);
    // states other than S_DOWN1 in which the core clock runs at full rate
    wire full_speed = |(state & (S_RAMP2 | S_FWD0 | S_BUILT_IN_SELF_TEST | S_SELFINIT |
                                 S_FWD1 | S_RUN | S_FAULT));

    prcrfs_dur_counter u_dur (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(cnt_load),
        .target(cnt_target),
        .done(cnt_done)
    );

    ////////////////////////////////////////////////////////////////////
    // next state; counter loads on the same edge as the state change
    always @* begin
        next_state = state;
        cnt_load = 1'b0;
        cnt_target = `PRCRFS_LOW_CYCLES;
        case (state)
            S_COLD: begin
                if (!chip_n_s && pll_ok_s && core_ok_s) begin
                    next_state = S_SETTLE;
                end
            end
            S_SETTLE: begin
                if (pgood_s) begin
                    next_state = S_NOMINAL;
                end
            end
            S_NOMINAL: begin
                if (chip_n_s) begin
                    next_state = S_RAMP1;
                    cnt_load = 1'b1;
                    cnt_target = HALF_RAMP_CYCLES;
                end
            end
            S_RAMP1: begin
                if (cnt_done) begin
                    next_state = S_RAMP2;
                    cnt_load = 1'b1;
                    cnt_target = FULL_RAMP_CYCLES;
                end
            end
            S_RAMP2: begin
                if (cnt_done) begin
                    next_state = S_FWD0;
                end
            end
            S_FWD0: begin
                // waking skips self-test and rom load entirely
                if (release_fall) begin
                    next_state = wake ? S_SELFINIT : S_BUILT_IN_SELF_TEST;
                    cnt_load = 1'b1;
                    cnt_target = wake ? `PRCRFS_SELFINIT_CYCLES :
                                        `PRCRFS_BUILT_IN_SELF_TEST_CYCLES;
                end
            end
            S_BUILT_IN_SELF_TEST: begin
                if (cnt_done && rom_phase == ROM_DONE) begin
                    next_state = S_FWD1;
                end
            end
            S_SELFINIT: begin
                if (cnt_done) begin
                    next_state = S_FWD1;
                end
            end
            S_FWD1: begin
                if (release_rise) begin
                    next_state = S_RUN;
                end
            end
            S_RUN: begin
                // a fault outranks a pending sleep request
                if (fcr_s) begin
                    next_state = S_FAULT;
                end else if (sleep_req) begin
                    next_state = S_DOWN1;
                    cnt_load = 1'b1;
                    cnt_target = FULL_RAMP_CYCLES;
                end
            end
            S_FAULT: begin
                if (!fcr_s) begin
                    next_state = S_RUN;
                end
            end
            S_DOWN1: begin
                if (cnt_done) begin
                    next_state = S_DOWN2;
                    cnt_load = 1'b1;
                    cnt_target = HALF_RAMP_CYCLES;
                end
            end
            S_DOWN2: begin
                if (cnt_done) begin
                    next_state = S_DOWN3;
                    cnt_load = 1'b1;
                    cnt_target = `PRCRFS_LOW_CYCLES;
                end
            end
            S_DOWN3: begin
                if (cnt_done) begin
                    next_state = sleep_mode ? S_WAIT_IRQ : S_WAIT_RESET;
                end
            end
            S_WAIT_IRQ: begin
                if (!chip_n_s) begin
                    next_state = S_WAIT_RESET;
                end else if (irq_hit) begin
                    next_state = S_RAMP1;
                    cnt_load = 1'b1;
                    cnt_target = HALF_RAMP_CYCLES;
                end
            end
            S_WAIT_RESET: begin
                // reset toggled while powered: back up to full rate
                if (chip_n_s) begin
                    next_state = S_FWD0;
                end
            end
            default: begin
                next_state = S_COLD;
            end
        endcase
        // chip reset overrides: pick the down ramp matching the clock rate
        if (!chip_n_s && full_speed) begin
            next_state = S_DOWN1;
            cnt_load = 1'b1;
            cnt_target = FULL_RAMP_CYCLES;
        end else if (!chip_n_s && state == S_RAMP1) begin
            next_state = S_DOWN2;
            cnt_load = 1'b1;
            cnt_target = HALF_RAMP_CYCLES;
        end
        // losing the pll supply drops the chip cold from anywhere
        if (!pll_ok_s) begin
            next_state = S_COLD;
            cnt_load = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register, mode flags and pll divisors
    always @(posedge mclk) begin
        if (!rst_n) begin
            state <= S_COLD;
            wake <= 1'b0;
            sleep_mode <= 1'b0;
            pll_x_div <= `PRCRFS_XDIV_SLOW;
            pll_z_div <= `PRCRFS_ZDIV_SLOW;
        end else begin
            state <= next_state;
            if (state == S_WAIT_IRQ && next_state == S_RAMP1) begin
                wake <= 1'b1;
            end else if (next_state == S_COLD || next_state == S_WAIT_RESET) begin
                wake <= 1'b0;
            end
            if (state == S_RUN && next_state == S_DOWN1 && chip_n_s) begin
                sleep_mode <= 1'b1;
            end else if (next_state == S_COLD || (next_state == S_DOWN1 && state != S_DOWN1)) begin
                sleep_mode <= 1'b0;
            end
            // divisors follow the state being entered
            if (|(next_state & (S_RAMP1 | S_DOWN2))) begin
                pll_x_div <= `PRCRFS_XDIV_HALF;
                pll_z_div <= `PRCRFS_ZDIV_HALF;
            end else if (|(next_state & (S_COLD | S_SETTLE | S_NOMINAL |
                                         S_DOWN3 | S_WAIT_IRQ | S_WAIT_RESET))) begin
                pll_x_div <= `PRCRFS_XDIV_SLOW;
                pll_z_div <= `PRCRFS_ZDIV_SLOW;
            end else begin
                pll_x_div <= `PRCRFS_XDIV_FULL;
                pll_z_div <= `PRCRFS_ZDIV_FULL;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin outputs towards the core and the system
    always @(posedge mclk) begin
        if (!rst_n) begin
            boot_rom_output_enable_n <= 1'b1;
            internal_reset_n <= 1'b0;
            fwd_if_reset <= 1'b0;
            fault_reset <= 1'b0;
            run_active <= 1'b0;
            icache_enable <= 1'b0;
            fetch_from_memory <= 1'b0;
            fetch_addr <= `PRCRFS_BASE_RESET;
        end else begin
            // rom enabled only for a power-up style load
            boot_rom_output_enable_n <= ~(|(next_state & (S_FWD0 | S_BUILT_IN_SELF_TEST)) &
                                          ~wake);
            // internal reset lifts on the rising-edge release only
            internal_reset_n <= |(next_state & (S_RUN | S_FAULT));
            fwd_if_reset <= (state == S_FWD1) && (next_state == S_RUN);
            fault_reset <= (next_state == S_FAULT);
            run_active <= (next_state == S_RUN);
            if (state == S_FWD1 && next_state == S_RUN) begin
                icache_enable <= ~wake;
                fetch_from_memory <= wake;
                fetch_addr <= code_base;
            end else if (state == S_FAULT && next_state == S_RUN) begin
                fetch_from_memory <= 1'b1;
                fetch_addr <= code_base + `PRCRFS_FAULT_OFFSET;
            end else if (next_state == S_DOWN1) begin
                icache_enable <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // serial boot rom stream during self-test
    reg [2:0] rom_tick; // half period timer for the rom clock
    reg [15:0] rom_bits; // bits taken in the current field
    reg [15:0] cfg_chain; // write-once configuration chain
    reg cfg_locked; // chain already written since reset
    reg [15:0] icache_bits; // icache bit count from the stream
    wire rom_wrap = (rom_tick == `PRCRFS_ROM_HALF_LAST);
    // sample on our falling rom clock edge: data settled a half period
    wire rom_shift = (state == S_BUILT_IN_SELF_TEST) & rom_wrap & boot_rom_clock;
    wire [15:0] cnt_shifted = {icache_bits[14:0], rom_s};

    always @(posedge mclk) begin
        if (!rst_n) begin
            rom_tick <= 3'h0;
            boot_rom_clock <= 1'b0;
            rom_phase <= ROM_CFG;
            rom_bits <= 16'h0000;
            cfg_chain <= 16'h0000;
            cfg_locked <= 1'b0;
            icache_bits <= 16'h0000;
        end else if (state != S_BUILT_IN_SELF_TEST) begin
            // park the stream so each self-test starts at its head
            rom_tick <= 3'h0;
            boot_rom_clock <= 1'b0;
            rom_phase <= ROM_CFG;
            rom_bits <= 16'h0000;
        end else begin
            rom_tick <= rom_wrap ? 3'h0 : rom_tick + 3'h1;
            if (rom_wrap && rom_phase != ROM_DONE) begin
                boot_rom_clock <= ~boot_rom_clock;
            end
            if (rom_shift) begin
                case (rom_phase)
                    ROM_CFG: begin
                        // write-once: later loads pass over the chain
                        if (!cfg_locked) begin
                            cfg_chain <= {cfg_chain[14:0], rom_s};
                        end
                        rom_bits <= rom_bits + 16'h0001;
                        if (rom_bits == `PRCRFS_ROM_FIELD_LAST) begin
                            rom_phase <= ROM_CNT;
                            rom_bits <= 16'h0000;
                            cfg_locked <= 1'b1;
                        end
                    end
                    ROM_CNT: begin
                        icache_bits <= cnt_shifted;
                        rom_bits <= rom_bits + 16'h0001;
                        if (rom_bits == `PRCRFS_ROM_FIELD_LAST) begin
                            rom_bits <= 16'h0000;
                            rom_phase <= (cnt_shifted == 16'h0000) ?
                                         ROM_DONE : ROM_DATA;
                        end
                    end
                    ROM_DATA: begin
                        rom_bits <= rom_bits + 16'h0001;
                        if (rom_bits == icache_bits - 16'h0001) begin
                            rom_phase <= ROM_DONE;
                        end
                    end
                    ROM_DONE: begin
                        rom_phase <= ROM_DONE;
                    end
                    default: begin
                        rom_phase <= ROM_CFG;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // avalon-mm slave: one wait cycle on every access
    wire acc_start = (avs_read | avs_write) & avs_waitrequest;
    wire wr_fire = avs_write & ~avs_waitrequest;
    wire sleep_wr = wr_fire & (avs_address == `PRCRFS_REG_CTRL) &
                    avs_writedata[`PRCRFS_CTRL_SLEEP];
    wire sleep_take = (state == S_RUN) && (next_state == S_DOWN1);

    // waitrequest drops for exactly the completing cycle
    always @(posedge mclk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            avs_waitrequest <= ~acc_start;
            if (acc_start && avs_read) begin
                case (avs_address)
                    `PRCRFS_REG_CTRL: avs_readdata <= {29'h00000000,
                                                      irq_en, sleep_req};
                    `PRCRFS_REG_BASE: avs_readdata <= code_base;
                    `PRCRFS_REG_STATUS: avs_readdata <= {12'h000, rom_phase[3],
                                                        rom_phase[2], sleep_mode,
                                                        wake, state};
                    `PRCRFS_REG_CFG: avs_readdata <= {16'h0000, cfg_chain};
                    `PRCRFS_REG_ICNT: avs_readdata <= {16'h0000, icache_bits};
                    `PRCRFS_REG_FETCH: avs_readdata <= fetch_addr;
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // software registers; a new sleep write beats the hardware take
    always @(posedge mclk) begin
        if (!rst_n) begin
            sleep_req <= 1'b0;
            irq_en <= `PRCRFS_CTRL_EN_RESET;
            code_base <= `PRCRFS_BASE_RESET;
        end else begin
            if (sleep_wr) begin
                sleep_req <= 1'b1;
            end else if (sleep_take) begin
                sleep_req <= 1'b0;
            end
            if (wr_fire && avs_address == `PRCRFS_REG_CTRL) begin
                irq_en <= avs_writedata[`PRCRFS_CTRL_DEVIRQ_EN:`PRCRFS_CTRL_CLKIRQ_EN];
            end
            if (wr_fire && avs_address == `PRCRFS_REG_BASE) begin
                code_base <= avs_writedata;
            end
        end
    end
endmodule
`default_nettype wire

// file: dv/prcrfs_monitor.sv
`default_nettype none
module prcrfs_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic forwarded_clock_reset,
    input wire logic boot_rom_output_enable_n,
    input wire logic boot_rom_clock,
    input wire logic [4:0] pll_x_div,
    input wire logic [5:0] pll_z_div,
    input wire logic internal_reset_n,
    input wire logic fwd_if_reset,
    input wire logic fault_reset,
    input wire logic run_active,
    input wire logic icache_enable,
    input wire logic fetch_from_memory
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // only the three documented divisor pairs may ever reach the pll
    property p_div; (pll_x_div == 5'h10 && pll_z_div == 6'h20) || (pll_x_div == 5'h02 &&
        pll_z_div == 6'h04) || (pll_x_div == 5'h01 && pll_z_div == 6'h02); endproperty
    a_div: assert property (p_div) else $error("bad divisors");
    property p_run; run_active |-> internal_reset_n && boot_rom_output_enable_n; endproperty
    a_run: assert property (p_run) else $error("run levels");
    property p_irst; internal_reset_n |-> run_active || fault_reset; endproperty
    a_irst: assert property (p_irst) else $error("core out of reset");
    property p_fwd; fwd_if_reset |=> run_active && !fwd_if_reset; endproperty
    a_fwd: assert property (p_fwd) else $error("interface reset");
    // two sync flops plus the state edge
    property p_flt; run_active && forwarded_clock_reset |-> ##[1:4] !run_active; endproperty
    a_flt: assert property (p_flt) else $error("fault missed");
    property p_fflt; $fell(fault_reset) && run_active |-> fetch_from_memory; endproperty
    a_fflt: assert property (p_fflt) else $error("fault fetch");
    property p_rom; boot_rom_clock |-> !boot_rom_output_enable_n; endproperty
    a_rom: assert property (p_rom) else $error("rom clock idle");
    property p_ic; fwd_if_reset |-> icache_enable ^ fetch_from_memory; endproperty
    a_ic: assert property (p_ic) else $error("code source");
endmodule
bind prcrfs_top prcrfs_monitor i_mon (.*);
`default_nettype wire

// file: dv/prcrfs_sys.sv
`default_nettype none
module prcrfs_sys (
    input wire logic fwd_req,
    input wire logic on_rise,
    input wire logic boot_rom_clock,
    input wire logic boot_rom_output_enable_n,
    output var logic frame_reference_clock,
    output var logic forwarded_clock_reset,
    output var logic boot_rom_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [34:0] rom = {16'hA5C3, 16'h0003, 3'h5};  // chain, count, code bits
    // frame clock runs free, offset from the core clock
    initial begin
        frame_reference_clock = 0;
        forwarded_clock_reset = 1;
        boot_rom_data = 0;
        #3;
        forever #40 frame_reference_clock = ~frame_reference_clock;
    end
    // falling frame edge in the first wait, rising edge in the second
    always @(frame_reference_clock) if (frame_reference_clock == on_rise) forwarded_clock_reset <= fwd_req;
    // msb first, new bit after each rom clock rise
    always @(posedge boot_rom_clock) begin
        boot_rom_data <= rom[34];
        rom <= {rom[33:0], 1'b0};
    end
    // deselected rom line wanders so stale data never reads as valid
    always @(frame_reference_clock) if (boot_rom_output_enable_n) boot_rom_data <= ~boot_rom_data;
endmodule
`default_nettype wire

// file: dv/prcrfs_top_tb.sv
`default_nettype none
module prcrfs_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, chip_reset_n = 0;
    logic power_good = 0, clock_irq = 0, device_irq = 0, fwd_req = 1, on_rise = 0;
    logic core_supply_ok = 0, pll_supply_ok = 1;
    logic [2:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, rdat = 0;
    wire [31:0] avs_readdata, fetch_addr;
    wire [4:0] pll_x_div;
    wire [5:0] pll_z_div;
    wire avs_waitrequest, boot_rom_output_enable_n, boot_rom_clock, internal_reset_n;
    wire fwd_if_reset, fault_reset, run_active, icache_enable, fetch_from_memory;
    wire frame_reference_clock, forwarded_clock_reset, boot_rom_data;
    int mismatches = 0, num_checks = 0;
    // short ramps keep the run brief
    prcrfs_top #(.HALF_RAMP_CYCLES(14'h14), .FULL_RAMP_CYCLES(14'h28)) i_dut (.*);
    prcrfs_sys i_sys (.*);
    always #4 mclk = ~mclk;
    task chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // request held until waitrequest is sampled low
    task bus(input logic [2:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= d;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic ws(input logic [15:0] m);
        bus(3'h2, 0, 0);
        for (int n = 0; n < 5000 && rdat[15:0] !== m; n++) bus(3'h2, 0, 0);
        chk(rdat[15:0] === m, "state");
    endtask
    // cycles the half-speed divisor stands
    task automatic hold(input int n);
        int c;
        for (c = 0; pll_x_div !== 5'h02 && c < 9999; c++) @(negedge mclk);
        for (c = 0; pll_x_div === 5'h02 && c < 9999; c++) @(negedge mclk);
        chk(c == n, "ramp len");
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1;
        ws(16'h0001);
        core_supply_ok <= 1;
        ws(16'h0002);
        bus(3'h7, 0, 0);
        chk(rdat === 0, "unmapped");
        power_good <= 1;
        ws(16'h0004);
        chk(pll_x_div === 5'h10 && pll_z_div === 6'h20, "slow");
        chip_reset_n <= 1;
        hold(20);
        ws(16'h0020);
        chk(!boot_rom_output_enable_n && pll_x_div === 5'h01, "rom on");
        fwd_req <= 0;
        ws(16'h0040);
        fwd_req <= 1;
        on_rise <= 1;
        ws(16'h0100);
        chk(boot_rom_output_enable_n === 1, "rom off");
        fwd_req <= 0;
        ws(16'h0200);
        chk(icache_enable === 1 && fetch_from_memory === 0, "boot");
        bus(3'h3, 0, 0);
        chk(rdat[15:0] === 16'hA5C3, "chain");
        bus(3'h4, 0, 0);
        chk(rdat[15:0] === 16'h0003, "count");
        $display("boot test done");
        bus(3'h1, 1, 32'h00001000);
        fwd_req <= 1;
        ws(16'h0400);
        fwd_req <= 0;
        ws(16'h0200);
        chk(fetch_addr === 32'h00001780 && fetch_from_memory === 1, "fault");
        $display("fault test done");
        bus(3'h0, 1, 32'h00000003);
        hold(20);
        fwd_req <= 1;
        on_rise <= 0;
        ws(16'h4000);
        device_irq <= 1;
        repeat (2) ws(16'h4000);
        clock_irq <= 1;
        ws(16'h0020);
        clock_irq <= 0;
        fwd_req <= 0;
        ws(16'h0080);
        fwd_req <= 1;
        on_rise <= 1;
        ws(16'h0100);
        fwd_req <= 0;
        ws(16'h0200);
        chk(!icache_enable && fetch_from_memory && boot_rom_output_enable_n, "wake");
        $display("sleep test done");
        chip_reset_n <= 0;
        ws(16'h8000);
        chip_reset_n <= 1;
        ws(16'h0020);
        chk(pll_x_div === 5'h01, "full");
        $display("reset test done");
        report_and_stop();
    end
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
